//--- design/debug_interrupt_entry_map.svh
/*
 * Offsets, field positions, reset values and vector offsets for the
 * debug interrupt entry block.
 * Assumes a 32-bit APB register port and bit 0 as the word's MSB.
 */
// Behaviour
// - Breakpoint, peripheral or port request takes debug
// - Instruction breakpoint saves triggering instruction address
// - Data breakpoint saves following instruction address
// - Maskable or peripheral request saves next address
// - Port request during reset leaves saved state undefined
// - Entry clears saved state bits 1:4, 10:15
// - Saved bits 16:31 copied from machine state 16:31, bits 0, 5:9 cleared
// - Saved bit 30 follows recoverable flag only
// - Entry keeps prefix, machine check; endian from interrupt
// - Data breakpoint loads breakpoint address, keeps fault regs
// - Instruction breakpoint vectors to offset 0x01D00
// - Data breakpoint vectors to offset 0x01C00
// - Maskable or peripheral request vectors to 0x01E00
// - Non-maskable port request vectors to 0x01F00
// - Alignment fault suppresses the whole instruction
// - Architected data storage interrupt never raised
// - Partial execution only for multi-access or unaligned load/store
// - Later unaligned store access fault takes protection
// - Partial update-form never writes base register
// - Unimplemented optional instruction takes software emulation
`ifndef DEBUG_INTERRUPT_ENTRY_MAP_SVH
`define DEBUG_INTERRUPT_ENTRY_MAP_SVH

// Register byte offsets on the APB port
`define OFF_MSTATE 12'h000
`define OFF_SAVE_PC 12'h004
`define OFF_SAVE_STATE 12'h008
`define OFF_BRK_ADDR 12'h00C
`define OFF_DATA_ADDR 12'h010
`define OFF_FAULT_STATUS 12'h014
`define OFF_ENTRY_STATUS 12'h018
`define OFF_FETCH_TARGET 12'h01C

// Machine state bit numbers, bit 0 is the MSB
`define MS_IENDIAN 15
`define MS_EXT_EN 16
`define MS_MCHK 19
`define MS_PREFIX 25
`define MS_RECOV 30
`define MS_ENDIAN 31

// Saved-state bits cleared on entry (1:4 and 10:15) and copied (16:31)
`define SAVE_CLEAR_MASK 32'h783F_0000
`define SAVE_COPY_MASK 32'h0000_FFFF

// Fault status bit numbers for the protection interrupt
`define FAULT_PROT 4
`define FAULT_STORE 6

// Vector bases and offsets
`define VEC_BASE_LOW 32'h0000_0000
`define VEC_BASE_HIGH 32'hFFF0_0000
`define VEC_EMULATION 32'h0000_1000
`define VEC_DATA_PROT 32'h0000_1400
`define VEC_DATA_BRK 32'h0000_1C00
`define VEC_INSTR_BRK 32'h0000_1D00
`define VEC_MASKABLE 32'h0000_1E00
`define VEC_NON_MASKABLE 32'h0000_1F00

// Reset values
`define MS_RESET 32'h0000_0040
`define WORD_RESET 32'h0000_0000

`endif

//--- design/debug_interrupt_entry_pkg.sv
/*
 * Types shared by the debug interrupt entry block and its bench.
 * Assumes the constants header supplies every number.
 */
package debug_interrupt_entry_pkg;

    // Cause of the last interrupt entry
    typedef enum logic [2:0] {
        CAUSE_NONE = 3'b000,
        CAUSE_INSTR_BRK = 3'b001,
        CAUSE_DATA_BRK = 3'b010,
        CAUSE_MASKABLE = 3'b011,
        CAUSE_NON_MASKABLE = 3'b100,
        CAUSE_DATA_PROT = 3'b101,
        CAUSE_EMULATION = 3'b110
    } cause_t;

    // Debug requests from breakpoint logic and the development port
    typedef struct packed {
        logic instr_brk;
        logic data_brk;
        logic periph_brk;
        logic port_maskable;
        logic port_non_maskable;
    } debug_req_t;

    // Addresses the core offers alongside a request
    typedef struct packed {
        logic [31:0] instr_ea;
        logic [31:0] following_ea;
        logic [31:0] next_ea;
        logic [31:0] data_ea;
    } core_addr_t;

    // One load/store access as the core presents it
    typedef struct packed {
        logic valid;
        logic multi_access;
        logic unaligned;
        logic store;
        logic update_form;
        logic align_fault;
        logic prot_fault;
        logic first_access;
        logic unimplemented_opt;
    } lsu_access_t;

    // Verdict returned to the load/store unit
    typedef struct packed {
        logic suppress;
        logic base_update_en;
        logic partial;
        logic data_storage_int;
    } lsu_verdict_t;

endpackage

//--- design/debug_interrupt_entry.sv
/*
 * Debug interrupt entry: takes debug, protection and emulation
 * interrupts, updates the saved and machine state registers, and
 * steers fetch to the vector. Registers are reached over APB.
 * Assumes requests and addresses are synchronous to clock, and that
 * the core holds the instruction until the verdict cycle ends.
 */
`timescale 1ns/1ns
`include "debug_interrupt_entry_map.svh"

module debug_interrupt_entry #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core side
    input wire debug_interrupt_entry_pkg::debug_req_t debug_req,
    input wire debug_interrupt_entry_pkg::core_addr_t core_addr,
    input wire debug_interrupt_entry_pkg::lsu_access_t lsu_access,
    output debug_interrupt_entry_pkg::lsu_verdict_t lsu_verdict,
    output logic take_interrupt,
    output logic [31:0] fetch_target,
    output logic [31:0] machine_state_register,
    output logic [31:0] save_restore_pc,
    output logic [31:0] save_restore_state
);

    // Address decode below needs at least the byte offsets in use
    if (ADDR_WIDTH < 5 || ADDR_WIDTH > 32) begin : g_width_check
        $error("ADDR_WIDTH must lie between 5 and 32");
    end

    // Converts a bit number with bit 0 as MSB to a vector index
    function automatic int unsigned bit_index(input int unsigned be_bit);
        bit_index = 31 - be_bit;
    endfunction

    // Software-visible state
    logic [31:0] breakpoint_address_reg; // Data address of a data breakpoint
    logic [31:0] data_address_reg; // Data address of a protection fault
    logic [31:0] data_fault_status; // Cause bits of a protection fault
    debug_interrupt_entry_pkg::cause_t last_cause; // Cause of last entry
    logic saved_undefined; // Port request seen during reset
    logic non_maskable_seen; // Previous level of the non-maskable request

    // Entry decisions
    debug_interrupt_entry_pkg::cause_t next_cause; // Cause taken this cycle
    logic [31:0] next_save_pc; // Address to save on entry
    logic [31:0] vector_offset; // Offset for the cause taken
    logic [31:0] vector_base; // Base picked by the prefix select
    logic [31:0] entry_state; // Saved-state image
    logic [31:0] entry_mstate; // Machine state after entry
    logic maskable_enabled; // External interrupt enable in machine state
    logic non_maskable_edge; // Rising edge of the non-maskable request
    logic prot_take; // Protection interrupt this cycle
    logic emul_take; // Emulation interrupt this cycle

    // APB decode
    logic [ADDR_WIDTH-1:0] word_addr; // Byte address with low bits cleared
    logic apb_access; // Access phase of a transfer
    logic apb_write; // Write that takes effect now
    logic addr_mapped; // Address hits a register
    logic addr_read_only; // Address hits a read-only register

    // The port is always ready, so every access phase completes at once
    assign apb_access = psel && penable;
    assign word_addr = {paddr[ADDR_WIDTH-1:2], 2'b00};
    assign pready = 1'b1;

    // Register decode; read-only registers refuse writes with an error
    always_comb begin
        addr_mapped = 1'b1;
        addr_read_only = 1'b0;
        case (word_addr)
            ADDR_WIDTH'(`OFF_MSTATE): addr_read_only = 1'b0;
            ADDR_WIDTH'(`OFF_SAVE_PC): addr_read_only = 1'b0;
            ADDR_WIDTH'(`OFF_SAVE_STATE): addr_read_only = 1'b0;
            ADDR_WIDTH'(`OFF_BRK_ADDR): addr_read_only = 1'b1;
            ADDR_WIDTH'(`OFF_DATA_ADDR): addr_read_only = 1'b0;
            ADDR_WIDTH'(`OFF_FAULT_STATUS): addr_read_only = 1'b0;
            ADDR_WIDTH'(`OFF_ENTRY_STATUS): addr_read_only = 1'b1;
            ADDR_WIDTH'(`OFF_FETCH_TARGET): addr_read_only = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    end

    // Error answer for unmapped addresses and writes to read-only words
    assign pslverr = apb_access && (!addr_mapped || (pwrite && addr_read_only));
    assign apb_write = apb_access && pwrite && addr_mapped && !addr_read_only;

    // Read data mux; driven in the access phase only, zero otherwise
    always_comb begin
        prdata = 32'h0000_0000;
        if (apb_access && !pwrite) begin
            case (word_addr)
                ADDR_WIDTH'(`OFF_MSTATE): prdata = machine_state_register;
                ADDR_WIDTH'(`OFF_SAVE_PC): prdata = save_restore_pc;
                ADDR_WIDTH'(`OFF_SAVE_STATE): prdata = save_restore_state;
                ADDR_WIDTH'(`OFF_BRK_ADDR): prdata = breakpoint_address_reg;
                ADDR_WIDTH'(`OFF_DATA_ADDR): prdata = data_address_reg;
                ADDR_WIDTH'(`OFF_FAULT_STATUS): prdata = data_fault_status;
                ADDR_WIDTH'(`OFF_ENTRY_STATUS): begin
                    prdata = {27'h000_0000, saved_undefined, 1'b0, last_cause};
                end
                ADDR_WIDTH'(`OFF_FETCH_TARGET): prdata = fetch_target;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // Maskable sources wait for the enable bit, which entry clears
    assign maskable_enabled = machine_state_register[bit_index(`MS_EXT_EN)];
    // A held non-maskable level must not re-enter every cycle
    assign non_maskable_edge = debug_req.port_non_maskable && !non_maskable_seen;

    // Load/store verdict: partial work only for multi-access or unaligned operations
    always_comb begin
        lsu_verdict.suppress = 1'b0;
        lsu_verdict.partial = 1'b0;
        lsu_verdict.base_update_en = lsu_access.valid && lsu_access.update_form;
        // The architected data storage interrupt is never raised
        lsu_verdict.data_storage_int = 1'b0;
        prot_take = 1'b0;
        if (lsu_access.valid && lsu_access.align_fault) begin
            // Nothing of the instruction runs, base included
            lsu_verdict.suppress = 1'b1;
            lsu_verdict.base_update_en = 1'b0;
        end else if (lsu_access.valid && lsu_access.prot_fault) begin
            // Storage faults go to the protection interrupt instead
            prot_take = 1'b1;
            lsu_verdict.base_update_en = 1'b0;
            if (lsu_access.multi_access || lsu_access.unaligned) begin
                // Earlier accesses of the same instruction stay done
                lsu_verdict.partial = !lsu_access.first_access;
                lsu_verdict.suppress = lsu_access.first_access;
            end else begin
                // A single access never leaves partial work behind
                lsu_verdict.suppress = 1'b1;
            end
        end
    end

    // Unimplemented optional instructions go to software emulation
    assign emul_take = lsu_access.valid && lsu_access.unimplemented_opt;

    // Cause arbitration: the non-maskable port request ranks first
    always_comb begin
        next_cause = debug_interrupt_entry_pkg::CAUSE_NONE;
        if (non_maskable_edge) begin
            next_cause = debug_interrupt_entry_pkg::CAUSE_NON_MASKABLE;
        end else if (debug_req.instr_brk) begin
            next_cause = debug_interrupt_entry_pkg::CAUSE_INSTR_BRK;
        end else if (debug_req.data_brk) begin
            next_cause = debug_interrupt_entry_pkg::CAUSE_DATA_BRK;
        end else if ((debug_req.port_maskable || debug_req.periph_brk)
                && maskable_enabled) begin
            next_cause = debug_interrupt_entry_pkg::CAUSE_MASKABLE;
        end else if (prot_take) begin
            next_cause = debug_interrupt_entry_pkg::CAUSE_DATA_PROT;
        end else if (emul_take) begin
            next_cause = debug_interrupt_entry_pkg::CAUSE_EMULATION;
        end
    end

    // Saved address and vector offset for the cause taken
    always_comb begin
        case (next_cause)
            debug_interrupt_entry_pkg::CAUSE_INSTR_BRK: begin
                next_save_pc = core_addr.instr_ea;
                vector_offset = `VEC_INSTR_BRK;
            end
            debug_interrupt_entry_pkg::CAUSE_DATA_BRK: begin
                next_save_pc = core_addr.following_ea;
                vector_offset = `VEC_DATA_BRK;
            end
            debug_interrupt_entry_pkg::CAUSE_MASKABLE: begin
                next_save_pc = core_addr.next_ea;
                vector_offset = `VEC_MASKABLE;
            end
            debug_interrupt_entry_pkg::CAUSE_NON_MASKABLE: begin
                // Saves the next address; no precise point exists here
                next_save_pc = core_addr.next_ea;
                vector_offset = `VEC_NON_MASKABLE;
            end
            debug_interrupt_entry_pkg::CAUSE_DATA_PROT: begin
                next_save_pc = core_addr.instr_ea;
                vector_offset = `VEC_DATA_PROT;
            end
            debug_interrupt_entry_pkg::CAUSE_EMULATION: begin
                next_save_pc = core_addr.instr_ea;
                vector_offset = `VEC_EMULATION;
            end
            default: begin
                next_save_pc = core_addr.instr_ea;
                vector_offset = `VEC_EMULATION;
            end
        endcase
    end

    // Base from the prefix select bit of the current machine state
    assign vector_base = machine_state_register[bit_index(`MS_PREFIX)]
        ? `VEC_BASE_HIGH : `VEC_BASE_LOW;

    // Saved state: copy 16:31, clear 1:4 and 10:15, bit 30 copied as is
    always_comb begin
        entry_state = machine_state_register & `SAVE_COPY_MASK;
        entry_state = entry_state & ~`SAVE_CLEAR_MASK;
    end

    // Machine state after entry: keep prefix and machine check, endian copied
    always_comb begin
        entry_mstate = 32'h0000_0000;
        entry_mstate[bit_index(`MS_PREFIX)] = machine_state_register[bit_index(`MS_PREFIX)];
        entry_mstate[bit_index(`MS_MCHK)] = machine_state_register[bit_index(`MS_MCHK)];
        entry_mstate[bit_index(`MS_ENDIAN)] = machine_state_register[bit_index(`MS_IENDIAN)];
    end

    // Machine state: entry beats a software write in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            machine_state_register <= `MS_RESET;
        end else if (next_cause != debug_interrupt_entry_pkg::CAUSE_NONE) begin
            machine_state_register <= entry_mstate;
        end else if (apb_write && word_addr == ADDR_WIDTH'(`OFF_MSTATE)) begin
            machine_state_register <= pwdata;
        end
    end

    // Saved address and saved state, loaded on every entry
    always_ff @(posedge clock) begin
        if (rst) begin
            save_restore_pc <= `WORD_RESET;
            save_restore_state <= `WORD_RESET;
        end else if (next_cause != debug_interrupt_entry_pkg::CAUSE_NONE) begin
            save_restore_pc <= next_save_pc;
            save_restore_state <= entry_state;
        end else if (apb_write && word_addr == ADDR_WIDTH'(`OFF_SAVE_PC)) begin
            save_restore_pc <= pwdata;
        end else if (apb_write && word_addr == ADDR_WIDTH'(`OFF_SAVE_STATE)) begin
            save_restore_state <= pwdata;
        end
    end

    // Breakpoint address: only a data breakpoint loads it
    always_ff @(posedge clock) begin
        if (rst) begin
            breakpoint_address_reg <= `WORD_RESET;
        end else if (next_cause == debug_interrupt_entry_pkg::CAUSE_DATA_BRK) begin
            breakpoint_address_reg <= core_addr.data_ea;
        end
    end

    // Fault address and status: a data breakpoint leaves them alone
    always_ff @(posedge clock) begin
        if (rst) begin
            data_address_reg <= `WORD_RESET;
            data_fault_status <= `WORD_RESET;
        end else if (next_cause == debug_interrupt_entry_pkg::CAUSE_DATA_PROT) begin
            data_address_reg <= core_addr.data_ea;
            data_fault_status <= 32'h0000_0000;
            data_fault_status[bit_index(`FAULT_PROT)] <= 1'b1;
            data_fault_status[bit_index(`FAULT_STORE)] <= lsu_access.store;
        end else if (next_cause != debug_interrupt_entry_pkg::CAUSE_DATA_BRK) begin
            // Software may rewrite them unless a protection or data breakpoint entry competes
            if (apb_write && word_addr == ADDR_WIDTH'(`OFF_DATA_ADDR)) begin
                data_address_reg <= pwdata;
            end
            if (apb_write && word_addr == ADDR_WIDTH'(`OFF_FAULT_STATUS)) begin
                data_fault_status <= pwdata;
            end
        end
    end

    // Fetch redirect: one-cycle pulse with the vector held afterwards
    always_ff @(posedge clock) begin
        if (rst) begin
            take_interrupt <= 1'b0;
            fetch_target <= `WORD_RESET;
        end else begin
            take_interrupt <= next_cause != debug_interrupt_entry_pkg::CAUSE_NONE;
            if (next_cause != debug_interrupt_entry_pkg::CAUSE_NONE) begin
                fetch_target <= vector_base | vector_offset;
            end
        end
    end

    // Cause record and non-maskable edge tracking
    always_ff @(posedge clock) begin
        if (rst) begin
            last_cause <= debug_interrupt_entry_pkg::CAUSE_NONE;
            non_maskable_seen <= 1'b0;
        end else begin
            non_maskable_seen <= debug_req.port_non_maskable;
            if (next_cause != debug_interrupt_entry_pkg::CAUSE_NONE) begin
                last_cause <= next_cause;
            end
        end
    end

    // A port request during reset marks the saved pair untrustworthy;
    // the flag stays until software rewrites the saved address or saved state
    always_ff @(posedge clock) begin
        if (rst) begin
            if (debug_req.port_maskable || debug_req.port_non_maskable) begin
                saved_undefined <= 1'b1;
            end
        end else if (apb_write && (word_addr == ADDR_WIDTH'(`OFF_SAVE_PC)
                || word_addr == ADDR_WIDTH'(`OFF_SAVE_STATE))) begin
            saved_undefined <= 1'b0;
        end
    end

endmodule

//--- tb/debug_interrupt_entry_assertions.sv
/* Assertions on the debug interrupt entry ports.
   Assumes one clock domain and the top module's port types. */
`timescale 1ns/1ns
module debug_interrupt_entry_assertions (
    input wire logic clock,
    input wire logic rst,
    input wire debug_interrupt_entry_pkg::debug_req_t debug_req,
    input wire debug_interrupt_entry_pkg::core_addr_t core_addr,
    input wire debug_interrupt_entry_pkg::lsu_access_t lsu_access,
    input wire debug_interrupt_entry_pkg::lsu_verdict_t lsu_verdict,
    input wire logic take_interrupt,
    input wire logic [31:0] fetch_target,
    input wire logic [31:0] machine_state_register,
    input wire logic [31:0] save_restore_pc,
    input wire logic [31:0] save_restore_state
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Base follows the prefix bit, which entry keeps
    wire logic [31:0] base = machine_state_register[6] ? 32'hFFF0_0000 : 32'h0000_0000;
    // Each cause excludes the causes above it
    wire logic nm = debug_req.port_non_maskable;
    wire logic hi = debug_req.instr_brk || debug_req.data_brk || nm;
    wire logic ib = debug_req.instr_brk && !nm;
    wire logic db = debug_req.data_brk && !debug_req.instr_brk && !nm;
    wire logic lv = debug_req.periph_brk || debug_req.port_maskable;
    wire logic mk = lv && machine_state_register[15] && !hi;
    // Entry is one cycle of cause, then the pulse
    sequence s_took(c);
        c ##1 take_interrupt;
    endsequence
    property p_vec(c, off);
        s_took(c) |-> fetch_target == (base | off);
    endproperty
    AST_VEC_I: assert property (p_vec(ib, 32'h0000_1D00))
        else $error("bad instr brk vector");
    AST_VEC_D: assert property (p_vec(db, 32'h0000_1C00))
        else $error("bad data brk vector");
    AST_VEC_M: assert property (p_vec(mk, 32'h0000_1E00))
        else $error("bad maskable vector");
    AST_VEC_N: assert property (p_vec($rose(nm), 32'h0000_1F00))
        else $error("bad non-maskable vector");
    AST_SAVE_I: assert property (ib |=> save_restore_pc == $past(core_addr.instr_ea))
        else $error("bad instr brk saved pc");
    AST_SAVE_D: assert property (db |=> save_restore_pc == $past(core_addr.following_ea))
        else $error("bad data brk saved pc");
    AST_SAVED: assert property (take_interrupt |->
        save_restore_state == {16'h0000, $past(machine_state_register[15:0])})
        else $error("bad saved state");
    AST_MSTATE: assert property (take_interrupt |-> machine_state_register ==
        (($past(machine_state_register) & 32'h0000_1040) | 32'($past(machine_state_register[16]))))
        else $error("bad entry machine state");
    AST_DSI: assert property (lsu_verdict.data_storage_int == 1'b0)
        else $error("data storage interrupt raised");
    AST_ALIGN: assert property (lsu_access.valid && lsu_access.align_fault |->
        lsu_verdict.suppress && !lsu_verdict.base_update_en)
        else $error("alignment not suppressed");
    AST_PART: assert property (lsu_verdict.partial |-> lsu_access.valid &&
        (lsu_access.multi_access || lsu_access.unaligned) && !lsu_verdict.base_update_en)
        else $error("illegal partial execution");
endmodule
bind debug_interrupt_entry debug_interrupt_entry_assertions chk_i (
    .clock(clock), .rst(rst), .debug_req(debug_req), .core_addr(core_addr),
    .lsu_access(lsu_access), .lsu_verdict(lsu_verdict), .take_interrupt(take_interrupt),
    .fetch_target(fetch_target), .machine_state_register(machine_state_register),
    .save_restore_pc(save_restore_pc), .save_restore_state(save_restore_state)
);

//--- tb/debug_request_source.sv
/* Breakpoint logic and development port request source.
   Assumes its tasks are called right after a rising clock edge. */
`timescale 1ns/1ns
module debug_request_source (
    input wire logic clock,
    output debug_interrupt_entry_pkg::debug_req_t req,
    output debug_interrupt_entry_pkg::core_addr_t addr
);
    // Idle: no request, addresses hold no useful value
    initial begin
        req = '0;
        addr = '0;
    end
    // Holds a request and its addresses for hold edges
    task automatic fire(input debug_interrupt_entry_pkg::debug_req_t r,
                        input debug_interrupt_entry_pkg::core_addr_t a, input int hold);
        req <= r;
        addr <= a;
        repeat (hold) @(posedge clock);
        req <= '0;
        // Stale addresses are inverted, not kept
        addr <= ~a;
    endtask
endmodule

//--- tb/debug_interrupt_entry_tb_top.sv
/* Directed bench for debug interrupt entry over APB and the core side.
   Assumes the request source model drives requests and addresses. */
`timescale 1ns/1ns
module debug_interrupt_entry_tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    debug_interrupt_entry_pkg::debug_req_t debug_req;
    debug_interrupt_entry_pkg::core_addr_t core_addr;
    debug_interrupt_entry_pkg::lsu_access_t lsu_access = '0;
    debug_interrupt_entry_pkg::lsu_verdict_t lsu_verdict;
    logic take_interrupt;
    logic [31:0] fetch_target;
    logic [31:0] machine_state_register;
    logic [31:0] save_restore_pc;
    logic [31:0] save_restore_state;
    int unsigned failures = 0;
    int unsigned cmp_count = 0;
    int unsigned n_take = 0; // Entry pulses seen
    int unsigned t0;
    logic [31:0] q;
    logic e;
    logic [31:0] m;
    // Distinct addresses so a wrong pick shows
    debug_interrupt_entry_pkg::core_addr_t av = '{32'h0000_0100, 32'h0000_0104,
        32'h0000_0108, 32'h0000_2000};
    logic [31:0] vec [5] = '{32'h0000_1D00, 32'h0000_1C00, 32'h0000_1E00,
        32'h0000_1E00, 32'h0000_1F00};

    always #5 clock = ~clock;
    // Counts entry pulses while tasks block
    always @(posedge clock) begin
        if (take_interrupt === 1'b1) n_take <= n_take + 1;
    end

    debug_request_source src (.clock(clock), .req(debug_req), .addr(core_addr));
    debug_interrupt_entry DUT (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .debug_req, .core_addr, .lsu_access, .lsu_verdict,
        .take_interrupt, .fetch_target, .machine_state_register, .save_restore_pc,
        .save_restore_state);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready, idles one cycle after
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    // One load/store cycle with addresses held by the source
    task automatic lsu_case(input debug_interrupt_entry_pkg::lsu_access_t acc,
        input logic [3:0] mask, input logic [3:0] v, input int unsigned n,
        input logic [31:0] ft);
        t0 = n_take;
        fork
            src.fire('0, av, 2);
            begin
                lsu_access <= acc;
                #1;
                chk(32'(lsu_verdict & mask), 32'(v));
                @(posedge clock);
                lsu_access <= '0;
            end
        join
        @(posedge clock);
        #1;
        chk(32'(n_take - t0), 32'(n));
        if (n != 0) chk(fetch_target, ft);
        @(posedge clock);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog far past the expected run
    initial begin
        #20000;
        failures++;
        conclude();
    end

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(q, 32'h0000_0040);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        apb(1'b1, 12'h00C, 32'h1234_5678);
        chk(32'(e), 32'h0000_0001);
        apb(1'b1, 12'h010, 32'h0000_5A5A);
        // Each debug cause, alternating prefix, endian and recoverable bits
        for (int k = 0; k < 5; k++) begin
            m = k[0] ? 32'h0000_8000 : 32'h0001_D0C3;
            apb(1'b1, 12'h000, m);
            t0 = n_take;
            src.fire(debug_interrupt_entry_pkg::debug_req_t'(5'b10000 >> k), av, 1);
            repeat (2) @(posedge clock);
            #1;
            chk(32'(n_take - t0), 32'h0000_0001);
            chk(save_restore_pc, av[127 - 32 * (k > 2 ? 2 : k) -: 32]);
            chk(machine_state_register, (m & 32'h0000_1040) | 32'(m[16]));
            chk(fetch_target, (m[6] ? 32'hFFF0_0000 : 32'h0000_0000) | vec[k]);
            @(posedge clock);
            apb(1'b0, 12'h008, 32'h0000_0000);
            chk(q, {16'h0000, m[15:0]});
            if (k == 1) begin
                apb(1'b0, 12'h00C, 32'h0000_0000);
                chk(q, 32'h0000_2000);
                apb(1'b0, 12'h010, 32'h0000_0000);
                chk(q, 32'h0000_5A5A);
            end
        end
        // Maskable request refused while enable is clear
        apb(1'b1, 12'h000, 32'h0000_0000);
        t0 = n_take;
        src.fire(debug_interrupt_entry_pkg::debug_req_t'(5'b00110), av, 3);
        repeat (2) @(posedge clock);
        #1;
        chk(32'(n_take - t0), 32'h0000_0000);
        @(posedge clock);
        apb(1'b1, 12'h000, 32'h0001_D0C3);
        lsu_case('{valid:1'b1, unaligned:1'b1, update_form:1'b1, align_fault:1'b1,
            first_access:1'b1, default:1'b0}, 4'b1101, 4'b1000, 0, 32'h0);
        lsu_case('{valid:1'b1, unaligned:1'b1, store:1'b1, update_form:1'b1,
            prot_fault:1'b1, default:1'b0}, 4'b1111, 4'b0010, 1, 32'hFFF0_1400);
        apb(1'b0, 12'h014, 32'h0000_0000);
        chk(q, 32'h0A00_0000);
        lsu_case('{valid:1'b1, unimplemented_opt:1'b1, default:1'b0}, 4'b0001, 4'b0000,
            1, 32'hFFF0_1000);
        conclude();
    end
endmodule
